// file: rtl/pulse_counter_pkg.sv
package pulse_counter_pkg;

  // Counter geometry
  localparam int          CNT_W        = 16;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;

  // Register byte offsets (word aligned)
  localparam logic [3:0]  OFS_CTRL     = 4'h0;
  localparam logic [3:0]  OFS_PRESET   = 4'h4;
  localparam logic [3:0]  OFS_COUNT    = 4'h8;
  localparam logic [3:0]  OFS_STATUS   = 4'hC;
  localparam logic [4:0]  OFS_MASK     = 5'h10;

  // Control field positions
  localparam int          CTRL_LOAD    = 0;
  localparam int          CTRL_SETFLG  = 1;
  localparam int          CTRL_OUTSET  = 2;
  localparam int          CTRL_ARM     = 3;
  localparam int          CTRL_MODE    = 4;
  localparam int          CTRL_EN      = 6;

  // Status / mask field positions
  localparam int          ST_WRAP_UP   = 0;
  localparam int          ST_WRAP_DN   = 1;
  localparam int          ST_FLAG_CLR  = 2;
  localparam int          ST_OUT_OFF   = 3;
  localparam int          ST_W         = 4;

  // Reset values
  localparam logic [15:0] PRESET_RST   = 16'h0000;
  localparam logic [3:0]  MASK_RST     = 4'h0;

  // Count modes
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_GATED,
    MODE_ENCODER,
    MODE_OFF
  } count_mode_t;

  // Field input rate limit and resulting samples per half period
  localparam int          CLK_HZ       = 40_000_000;
  localparam int          IN_MAX_HZ    = 20_000;
  localparam int          HALF_CYC     = CLK_HZ / (2 * IN_MAX_HZ);

endpackage

// file: rtl/edge_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronised inputs and edges between front end and counter core
interface edge_sync_if;
  logic a_lvl;   // Synchronised input A
  logic b_lvl;   // Synchronised input B
  logic a_rise;  // Rising edge of A, one cycle
  logic a_fall;  // Falling edge of A, one cycle
  modport src (output a_lvl, output b_lvl, output a_rise, output a_fall);
  modport dst (input a_lvl, input b_lvl, input a_rise, input a_fall);
endinterface
`default_nettype wire

// file: rtl/input_sync.sv
`timescale 1ns/1ps
`default_nettype none
module input_sync (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Raw field pins
  input  wire logic   a_pin_i,
  input  wire logic   b_pin_i,
  // Synchronised view
  edge_sync_if.src    sync
);

  logic [1:0] a_meta_q, a_meta_d;  // Two-stage sync for A
  logic [1:0] b_meta_q, b_meta_d;  // Two-stage sync for B
  logic       a_old_q,  a_old_d;   // Previous synced A

  // Next values: stage 0 feeds only stage 1
  always_comb begin
    a_meta_d = {a_meta_q[0], a_pin_i};
    b_meta_d = {b_meta_q[0], b_pin_i};
    a_old_d  = a_meta_q[1];
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_meta_q <= 2'h0;
      b_meta_q <= 2'h0;
      a_old_q  <= 1'b0;
    end else begin
      a_meta_q <= a_meta_d;
      b_meta_q <= b_meta_d;
      a_old_q  <= a_old_d;
    end
  end

  // Edges only from the second stage
  assign sync.a_lvl  = a_meta_q[1];
  assign sync.b_lvl  = b_meta_q[1];
  assign sync.a_rise = a_meta_q[1] & ~a_old_q;
  assign sync.a_fall = ~a_meta_q[1] & a_old_q;

endmodule
`default_nettype wire

// file: rtl/pulse_counter.sv
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pulse_counter
  import pulse_counter_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Field pins
  input  wire logic        in_a_i,
  input  wire logic        in_b_i,
  output logic             counter_driven_output_o,
  // Interrupt
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input front end

  edge_sync_if sync ();

  input_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .a_pin_i (in_a_i),
    .b_pin_i (in_b_i),
    .sync    (sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        req;      // Live request not yet answered
  logic        wr_ctrl;  // Write strobe, control
  logic        wr_pre;   // Write strobe, preset
  logic        wr_mask;  // Write strobe, mask
  logic        rd_stat;  // Read of status, clears it

  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctrl = req & wb_we_i & (wb_adr_i == {1'b0, OFS_CTRL});
  assign wr_pre  = req & wb_we_i & (wb_adr_i == {1'b0, OFS_PRESET});
  assign wr_mask = req & wb_we_i & (wb_adr_i == OFS_MASK) & wb_sel_i[0];
  assign rd_stat = req & ~wb_we_i & (wb_adr_i == {1'b0, OFS_STATUS});
  // Slot base address and watchdog sharing sit on the carrier

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0]      count_q,  count_d;   // Running count
  logic [15:0]      preset_q, preset_d;  // Value to load
  count_mode_t      mode_q,   mode_d;    // Selected count mode
  logic             en_q,     en_d;      // Counting enable
  logic             arm_q,    arm_d;     // Output clear armed
  logic             flag_q,   flag_d;    // Internal terminal flag
  logic             out_q,    out_d;     // Process output
  logic [ST_W-1:0]  stat_q,   stat_d;    // Sticky events
  logic [ST_W-1:0]  mask_q,   mask_d;    // Interrupt mask
  logic             irq_q,    irq_d;     // Registered interrupt
  logic [31:0]      rdat_q,   rdat_d;    // Read data
  logic             ack_q,    ack_d;     // Bus acknowledge

  // Combinational step helpers
  logic             step_up;  // Count one up this cycle
  logic             step_dn;  // Count one down this cycle
  logic             load;     // Preset load command
  logic             hit_top;  // Up step lands on 65535
  logic             hit_bot;  // Down step lands on zero
  logic             wrap_up;  // Up step from 65535
  logic             wrap_dn;  // Down step from zero
  logic [ST_W-1:0]  ev;       // Events this cycle
  logic [15:0]      pre_mrg;  // Preset after byte lanes

  ////////////////////////////////////////////////////////////////////////////
  // Step qualification per mode
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case (mode_q)
      // Every rising edge of A
      MODE_SINGLE: step_up = sync.a_rise;
      // A counted only while B is high
      MODE_GATED:  step_up = sync.a_rise & sync.b_lvl;
      // B level at A rise gives direction
      MODE_ENCODER: begin
        step_up = sync.a_rise & ~sync.b_lvl;
        step_dn = sync.a_rise &  sync.b_lvl;
      end
      MODE_OFF:    step_up = 1'b0;
      default:     step_up = 1'b0;
    endcase
    if (!en_q) begin
      step_up = 1'b0;
      step_dn = 1'b0;
    end
  end

  // Range end detection
  assign load    = wr_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_LOAD];
  assign hit_top = step_up & (count_q == CNT_MAX - 16'h0001);
  assign hit_bot = step_dn & (count_q == CNT_ZERO + 16'h0001);
  assign wrap_up = step_up & (count_q == CNT_MAX);
  assign wrap_dn = step_dn & (count_q == CNT_ZERO);

  ////////////////////////////////////////////////////////////////////////////
  // Counter, flag and output next values
  always_comb begin
    count_d  = count_q;
    preset_d = preset_q;
    mode_d   = mode_q;
    en_d     = en_q;
    arm_d    = arm_q;
    flag_d   = flag_q;
    out_d    = out_q;
    pre_mrg  = preset_q;
    // Preset writes by byte lane
    if (wb_sel_i[0]) pre_mrg[7:0]  = wb_dat_i[7:0];
    if (wb_sel_i[1]) pre_mrg[15:8] = wb_dat_i[15:8];
    if (wr_pre) begin
      preset_d = pre_mrg;
    end
    // Control writes: mode, enable, arm are levels
    if (wr_ctrl && wb_sel_i[0]) begin
      mode_d = count_mode_t'(wb_dat_i[CTRL_MODE +: 2]);
      en_d   = wb_dat_i[CTRL_EN];
      arm_d  = wb_dat_i[CTRL_ARM];
    end
    // Counting with wrap at both ends
    if (step_up) begin
      count_d = count_q + 16'h0001;
    end else if (step_dn) begin
      count_d = count_q - 16'h0001;
    end
    // Flag clears when a range end is reached
    if (hit_top || hit_bot) begin
      flag_d = 1'b0;
    end
    // Load and set command win over a clear
    if (load) begin
      count_d = preset_q;
      flag_d  = 1'b1;
    end
    if (wr_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_SETFLG]) begin
      flag_d = 1'b1;
    end
    // Armed range end drops the output at once, also on a later pass
    // whose flag is already clear
    if (arm_q && (hit_top || hit_bot) && !flag_d) begin
      out_d = 1'b0;
    end
    // Software raises the output
    if (wr_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_OUTSET]) begin
      out_d = 1'b1;
    end
  end

  // Registers for counter, flag and output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q  <= CNT_ZERO;
      preset_q <= PRESET_RST;
      mode_q   <= MODE_SINGLE;
      en_q     <= 1'b0;
      arm_q    <= 1'b0;
      flag_q   <= 1'b0;
      out_q    <= 1'b0;
    end else begin
      count_q  <= count_d;
      preset_q <= preset_d;
      mode_q   <= mode_d;
      en_q     <= en_d;
      arm_q    <= arm_d;
      flag_q   <= flag_d;
      out_q    <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and bus answer next values
  always_comb begin
    ev                   = '0;
    ev[ST_WRAP_UP]       = wrap_up;
    ev[ST_WRAP_DN]       = wrap_dn;
    ev[ST_FLAG_CLR]      = flag_q & ~flag_d;
    ev[ST_OUT_OFF]       = out_q & ~out_d;
    // Read clears, but a new event still wins
    stat_d               = (rd_stat ? '0 : stat_q) | ev;
    mask_d               = wr_mask ? wb_dat_i[ST_W-1:0] : mask_q;
    irq_d                = |(stat_d & mask_d);
    ack_d                = req;
    rdat_d               = 32'h0000_0000;
    // Flag itself is never placed on the read path
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        {1'b0, OFS_CTRL}:   rdat_d = {25'h0, en_q, mode_q, arm_q,
                                      out_q, 2'h0};
        {1'b0, OFS_PRESET}: rdat_d = {16'h0, preset_q};
        {1'b0, OFS_COUNT}:  rdat_d = {16'h0, count_q};
        {1'b0, OFS_STATUS}: rdat_d = {28'h0, stat_q};
        OFS_MASK:           rdat_d = {28'h0, mask_q};
        default:            rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // Registers for interrupt and bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
      mask_q <= MASK_RST;
      irq_q  <= 1'b0;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Outputs straight from flops
  assign wb_ack_o                = ack_q;
  assign wb_dat_o                = rdat_q;
  assign counter_driven_output_o = out_q;
  assign irq_o                   = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_load_sets_flag;
    @(posedge clk_i) disable iff (rst_i)
      load |=> flag_q && count_q == $past(preset_q);
  endproperty
  a_load_sets_flag: assert property (p_load_sets_flag)
    else $error("load did not set flag and count");

  property p_gate;
    @(posedge clk_i) disable iff (rst_i)
      (mode_q == MODE_GATED && !sync.b_lvl && !load) |=>
        count_q == $past(count_q);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated count moved with gate low");

  property p_enc_dn;
    @(posedge clk_i) disable iff (rst_i)
      (en_q && mode_q == MODE_ENCODER && sync.a_rise && sync.b_lvl
       && !load) |=> count_q == $past(count_q) - 16'h0001;
  endproperty
  a_enc_dn: assert property (p_enc_dn)
    else $error("encoder down step wrong");

  property p_wrap;
    @(posedge clk_i) disable iff (rst_i)
      (wrap_up && !load) |=> count_q == CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("no wrap to zero");

  property p_top_clear;
    @(posedge clk_i) disable iff (rst_i)
      (hit_top && !wr_ctrl) |=> !flag_q;
  endproperty
  a_top_clear: assert property (p_top_clear)
    else $error("flag not cleared at 65535");

  property p_out_drop;
    @(posedge clk_i) disable iff (rst_i)
      (arm_q && flag_q && hit_bot && !wr_ctrl) |=> !out_q && !flag_q;
  endproperty
  a_out_drop: assert property (p_out_drop)
    else $error("armed output did not drop with flag");

  property p_end_drop;
    @(posedge clk_i) disable iff (rst_i)
      (arm_q && (hit_top || hit_bot) && !wr_ctrl) |=> !out_q;
  endproperty
  a_end_drop: assert property (p_end_drop)
    else $error("armed range end left output on");

  property p_out_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!arm_q && !wr_ctrl) |=> out_q == $past(out_q);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("unarmed output changed");

  property p_one_step;
    @(posedge clk_i) disable iff (rst_i)
      (!sync.a_rise && !load) |=> count_q == $past(count_q);
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("count moved without edge");

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");

  c_load:  cover property (@(posedge clk_i) disable iff (rst_i) load);
  c_wrapd: cover property (@(posedge clk_i) disable iff (rst_i) wrap_dn);
  c_drop:  cover property (@(posedge clk_i) disable iff (rst_i)
                           $fell(out_q));
  c_irq:   cover property (@(posedge clk_i) disable iff (rst_i)
                           $rose(irq_o));

endmodule
`default_nettype wire

// file: tb/pulse_source.sv
`timescale 1ns/1ps
`default_nettype none
// Field pulse source or encoder standing in front of the counter pins
module pulse_source
  import pulse_counter_pkg::*;
(
  // Clock of the bench
  input  wire logic clk_i,
  // Field pins
  output logic      a_o,
  output logic      b_o
);
  // Both pins start low
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One pulse on A with B held at the given level
  // Half periods never shorter than at the fastest legal rate: high HALF_CYC cycles, low at least one cycle more
  task automatic pulse(input logic b_lvl);
    @(posedge clk_i);
    b_o <= b_lvl;                  // Set up direction or gate first
    repeat (HALF_CYC) @(posedge clk_i);
    a_o <= 1'b1;
    repeat (HALF_CYC) @(posedge clk_i);
    a_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/test_pulse_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the pulse counter through its bus and field pins
module test_pulse_counter
  import pulse_counter_pkg::*;
;
  // Control word pieces
  localparam logic [31:0] LD  = 32'h1 << CTRL_LOAD;
  localparam logic [31:0] SF  = 32'h1 << CTRL_SETFLG;
  localparam logic [31:0] OS  = 32'h1 << CTRL_OUTSET;
  localparam logic [31:0] AR  = 32'h1 << CTRL_ARM;
  localparam logic [31:0] EN  = 32'h1 << CTRL_EN;
  localparam logic [31:0] GT  = 32'h1 << CTRL_MODE;
  localparam logic [31:0] EC  = 32'h2 << CTRL_MODE;
  // Addresses widened to the bus
  localparam logic [4:0]  A_C = {1'b0, OFS_CTRL};
  localparam logic [4:0]  A_P = {1'b0, OFS_PRESET};
  localparam logic [4:0]  A_N = {1'b0, OFS_COUNT};
  localparam logic [4:0]  A_S = {1'b0, OFS_STATUS};

  logic        clk_i;     // Bench clock
  logic        rst_i;     // Reset
  logic        cyc;       // Bus cycle
  logic        stb;       // Bus strobe
  logic        we;        // Bus direction
  logic [4:0]  adr;       // Bus address
  logic [3:0]  sel;       // Byte lanes
  logic [31:0] wdat;      // Write data
  logic [31:0] rdat;      // Read data
  logic        ack;       // Bus answer
  logic        in_a;      // Count pin
  logic        in_b;      // Gate or direction pin
  logic        out_o;     // Process output
  logic        irq;       // Interrupt
  logic [31:0] q;         // Last read value
  int          n_errors;  // Mismatches
  int          n_checks;  // Comparisons
  int          passes;    // Passes through zero, counted by the bench

  ////////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  pulse_counter dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .in_a_i(in_a), .in_b_i(in_b),
    .counter_driven_output_o(out_o), .irq_o(irq)
  );

  pulse_source src (.clk_i(clk_i), .a_o(in_a), .b_o(in_b));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compare one value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One classic cycle; waits for ack under a bound
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 50);
    q = rdat;                      // Taken at the ack edge only
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 50) begin             // Hung slave ends the run
      n_errors++;
      test_done();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000, 4'hF);
    check(q, e);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst_i = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = 5'h00;
    sel = 4'hF;
    wdat = 32'h00000000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state, hidden flag, unmapped place reads zero
    for (int a = 0; a <= 20; a += 4) rd(a[4:0], 32'h00000000);
    check({31'h0, out_o | irq}, 32'h00000000);
    // Disabled counter ignores a pulse
    src.pulse(1'b0);
    rd(A_N, 32'h00000000);
    $display("test reset done");

    // Byte lanes: preset takes sel[1:0], control needs sel[0]
    wr(A_P, 32'h00001234);
    xfer(1'b1, A_P, 32'h0000ABCD, 4'h2);
    rd(A_P, 32'h0000AB34);
    xfer(1'b1, A_C, EN, 4'h2);
    rd(A_C, 32'h00000000);
    // Single mode counts every rise, off mode none
    wr(A_C, EN);
    src.pulse(1'b0);
    rd(A_N, 32'h00000001);
    wr(A_C, EN | (32'h3 << CTRL_MODE));
    src.pulse(1'b1);
    rd(A_N, 32'h00000001);
    $display("test lanes and modes done");

    // Gate low blocks, gate high passes one step
    wr(A_C, GT | EN);
    src.pulse(1'b0);
    rd(A_N, 32'h00000001);
    src.pulse(1'b1);
    rd(A_N, 32'h00000002);
    $display("test gated done");

    // Up to the top end with armed output, then wraps both ways
    xfer(1'b0, A_S, 32'h00000000, 4'hF);           // Drop stale events
    wr(A_P, 32'h0000FFFD);
    wr(A_C, EC | EN | LD);
    wr({1'b0, 4'h0} | OFS_MASK, 32'h0000000F);
    wr(A_C, EC | EN | AR | OS);
    check({31'h0, out_o}, 32'h1);
    rd(A_C, EC | EN | AR | OS);
    src.pulse(1'b0);
    check({31'h0, out_o}, 32'h1);
    src.pulse(1'b0);
    rd(A_N, 32'h0000FFFF);
    check({31'h0, out_o}, 32'h0);
    check({31'h0, irq}, 32'h1);
    rd(A_S, 32'h0000000C);
    check({31'h0, irq}, 32'h0);
    src.pulse(1'b0);
    rd(A_N, 32'h00000000);
    rd(A_S, 32'h00000001);
    wr(OFS_MASK, 32'h00000000);
    src.pulse(1'b1);
    check({31'h0, irq}, 32'h0);
    rd(A_N, 32'h0000FFFF);
    rd(A_S, 32'h00000002);
    $display("test encoder done");

    // Unarmed: flag clears at zero, output stays high
    wr(A_P, 32'h00000001);
    wr(A_C, EC | EN | LD);
    wr(A_C, EC | EN | OS);
    src.pulse(1'b1);
    rd(A_N, 32'h00000000);
    rd(A_S, 32'h00000004);
    check({31'h0, out_o}, 32'h1);
    $display("test unarmed done");

    // Set command and arm bit: the next clear at zero drops the output
    wr(A_C, EC | EN | AR | SF | OS);
    src.pulse(1'b0);
    check({31'h0, out_o}, 32'h1);
    src.pulse(1'b1);
    check({31'h0, out_o}, 32'h0);
    rd(A_S, 32'h0000000C);
    $display("test set command done");

    // Long range: arm only between the last two passes through zero
    wr(A_P, 32'h00000001);
    wr(A_C, EC | EN | LD | OS);
    passes = 0;
    src.pulse(1'b1);
    passes++;
    check({31'h0, out_o}, 32'h1);
    src.pulse(1'b0);
    if (passes == 1) wr(A_C, EC | EN | AR);
    src.pulse(1'b1);
    check({31'h0, out_o}, 32'h0);
    rd(A_S, 32'h0000000C);
    $display("test long range done");

    // Reset in mid-run drops the output and clears all state
    wr(A_C, OS);
    check({31'h0, out_o}, 32'h1);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check({31'h0, out_o | irq}, 32'h0);
    rd(A_P, 32'h00000000);
    rd(A_C, 32'h00000000);
    $display("test mid-run reset done");
    test_done();
  end
endmodule
`default_nettype wire
